/* File: wdt_top.sv */
`timescale 1ns/1ns
// Operation
// - Writing 1E then E1 to the key register enables an idle watchdog or clears a running counter.
// - The key register at A6 is write-only and reads return no meaningful contents.
// - After reset the timeout select reads zero, the shortest timeout.
// - The counter does not advance in power-down while the oscillator is stopped.
// - Power-down ends by hardware reset or a level external interrupt enabled beforehand.
// - After an interrupt wake-up the counter stays stopped while the wake pin is low.
// - The counter keeps running in idle mode since the oscillator runs.
// - The watchdog is off after reset and once on only a reset can turn it off.
// - On overflow the device resets and drives a high pulse of 96 oscillator periods on its reset pin.
// - The counter value cannot be read or written by software.
module wdt_top
(
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire wdt_pkg::wdt_sfr_req_type sfr_req,
    output logic [7:0]                    sfr_rdata,
    output logic                          sfr_hit,
    input  wire logic                     power_down,
    input  wire logic                     idle_mode,
    input  wire logic                     wake_int_n,
    output logic                          wdt_enabled,
    output logic                          wdt_reset_req,
    output logic                          rst_pin_out
);

    wdt_pkg::wdt_key_state_type           key_state_q;
    logic [wdt_pkg::sel_width_c-1:0]      sel_q;
    logic [wdt_pkg::cnt_width_c-1:0]      cnt_q;
    logic [wdt_pkg::cnt_width_c-1:0]      limit;
    logic [7:0]                           cfg_view;
    logic                                 en_q;
    logic                                 hold_q;
    logic                                 key_sel;
    logic                                 cfg_sel;
    logic                                 key_wr;
    logic                                 cfg_wr;
    logic                                 key_rd;
    logic                                 cfg_rd;
    logic                                 restart;
    logic                                 at_limit;
    logic                                 overflow;
    logic                                 run;

    // Address decode of the two watchdog registers
    assign key_sel = (sfr_req.addr == wdt_pkg::restart_key_addr_c);
    assign cfg_sel = (sfr_req.addr == wdt_pkg::timeout_config_addr_c);
    assign key_wr  = sfr_req.wr && key_sel;
    assign cfg_wr  = sfr_req.wr && cfg_sel;
    assign key_rd  = sfr_req.rd && key_sel;
    assign cfg_rd  = sfr_req.rd && cfg_sel;

    // Key sequence tracker
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            key_state_q <= wdt_pkg::wdt_key_idle_s;
        end
        else if (key_wr)
        begin
            case (key_state_q)
                wdt_pkg::wdt_key_idle_s:
                begin
                    if (sfr_req.wdata == wdt_pkg::key_first_c)
                        key_state_q <= wdt_pkg::wdt_key_armed_s;
                end
                wdt_pkg::wdt_key_armed_s:
                begin
                    if (sfr_req.wdata == wdt_pkg::key_first_c)
                        key_state_q <= wdt_pkg::wdt_key_armed_s;
                    else
                        key_state_q <= wdt_pkg::wdt_key_idle_s;
                end
                default:
                begin
                    key_state_q <= wdt_pkg::wdt_key_idle_s;
                end
            endcase
        end
    end

    assign restart = key_wr && (key_state_q == wdt_pkg::wdt_key_armed_s)
                     && (sfr_req.wdata == wdt_pkg::key_second_c);

    // Timeout select; reserved upper bits are not stored
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sel_q <= wdt_pkg::sel_reset_c;
        end
        else if (cfg_wr)
        begin
            sel_q <= sfr_req.wdata[wdt_pkg::sel_lsb_c +: wdt_pkg::sel_width_c];
        end
    end

    // Enable: cleared only by reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            en_q <= 1'b0;
        end
        else if (restart)
        begin
            en_q <= 1'b1;
        end
    end

    // Held after power-down until the wake pin returns high
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            hold_q <= 1'b0;
        end
        else if (power_down)
        begin
            hold_q <= 1'b1;
        end
        else if (wake_int_n)
        begin
            hold_q <= 1'b0;
        end
    end

    // Counting gate; idle mode keeps the oscillator and the counter running
    always_comb
    begin
        run = en_q;
        if (power_down)
        begin
            run = 1'b0;
        end
        if (hold_q)
        begin
            run = 1'b0;
        end
    end

    // Limit 2^(14+n)-1: bit i is set below the selected counter width
    for (genvar i = 0; i < wdt_pkg::cnt_width_c; i++)
    begin : g_limit
        assign limit[i] = (i < (wdt_pkg::base_bits_c + 32'(sel_q)));
    end

    assign at_limit = (cnt_q >= limit);
    assign overflow = run && at_limit;

    // Internal counter, never visible to software
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
        end
        else if (restart || overflow)
        begin
            cnt_q <= '0;
        end
        else if (run)
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wdt_reset_req <= 1'b0;
        end
        else
        begin
            wdt_reset_req <= overflow;
        end
    end

    // Config reads show the select bits, reserved bits as zero
    assign cfg_view = {{(8 - wdt_pkg::sel_width_c){1'b0}}, sel_q};

    // Key register reads as a constant
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sfr_rdata <= 8'h00;
        end
        else if (key_rd)
        begin
            sfr_rdata <= wdt_pkg::key_read_value_c;
        end
        else if (cfg_rd)
        begin
            sfr_rdata <= cfg_view;
        end
        else
        begin
            sfr_rdata <= 8'h00;
        end
    end

    assign sfr_hit = (sfr_req.rd || sfr_req.wr) && (key_sel || cfg_sel);

    assign wdt_enabled = en_q;

    wdt_rst_pulse u_rst_pulse
    (
        .clk         (clk),
        .nrst        (nrst),
        .trigger     (overflow),
        .rst_pin_out (rst_pin_out)
    );

endmodule // wdt_top

/* File: wdt_pkg.sv */
package wdt_pkg;

    // Special function register addresses
    localparam logic [7:0] restart_key_addr_c    = 8'hA6;
    localparam logic [7:0] timeout_config_addr_c = 8'hA7;

    // Restart key bytes
    localparam logic [7:0] key_first_c  = 8'h1E;
    localparam logic [7:0] key_second_c = 8'hE1;

    // Timeout select field
    localparam int unsigned sel_lsb_c   = 0;
    localparam int unsigned sel_width_c = 3;
    localparam logic [2:0]  sel_reset_c = 3'h0;

    // Counter: 14 base bits plus 7 prescaler bits
    localparam int unsigned base_bits_c = 14;
    localparam int unsigned cnt_width_c = 21;

    // Reset pulse of 96 oscillator periods, 12 oscillator periods per machine cycle
    localparam int unsigned rst_osc_periods_c = 96;
    localparam int unsigned osc_per_cycle_c   = 12;
    localparam int unsigned rst_cycles_c      = (rst_osc_periods_c + osc_per_cycle_c - 1) / osc_per_cycle_c;
    localparam int unsigned rst_cnt_width_c   = 4;

    // Read value of the write-only key register
    localparam logic [7:0] key_read_value_c = 8'h00;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdt_sfr_req_type;

    typedef enum logic [1:0]
    {
        wdt_key_idle_s  = 2'b01,
        wdt_key_armed_s = 2'b10
    } wdt_key_state_type;

endpackage

/* File: wdt_rst_pulse.sv */
`timescale 1ns/1ns
module wdt_rst_pulse
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic trigger,
    output logic      rst_pin_out
);

    logic [wdt_pkg::rst_cnt_width_c-1:0] cnt_q;

    // Stretches an overflow into the eight-cycle reset pulse
    always_ff @(posedge clk)
    begin
        if (!nrst)
            cnt_q <= '0;
        else if (trigger)
            cnt_q <= wdt_pkg::rst_cnt_width_c'(wdt_pkg::rst_cycles_c);
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rst_pin_out <= 1'b0;
        else
            rst_pin_out <= trigger || (cnt_q > wdt_pkg::rst_cnt_width_c'(1));
    end

endmodule // wdt_rst_pulse

/* File: wdt_top_assertions.sv */
`timescale 1ns/1ns
module wdt_top_assertions
(
    input wire logic                     clk,
    input wire logic                     nrst,
    input wire wdt_pkg::wdt_sfr_req_type sfr_req,
    input wire logic [7:0]               sfr_rdata,
    input wire logic                     sfr_hit,
    input wire logic                     power_down,
    input wire logic                     idle_mode,
    input wire logic                     wake_int_n,
    input wire logic                     wdt_enabled,
    input wire logic                     wdt_reset_req,
    input wire logic                     rst_pin_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_key_pair_enables: assert property (
        (sfr_req.wr && sfr_req.addr == 8'hA6 && sfr_req.wdata == 8'h1E) ##1
        (sfr_req.wr && sfr_req.addr == 8'hA6 && sfr_req.wdata == 8'hE1) |=> wdt_enabled) else $error("key no enable");
    a_stays_enabled: assert property (wdt_enabled |=> wdt_enabled) else $error("enable dropped");
    a_off_after_reset: assert property ($rose(nrst) |-> !wdt_enabled) else $error("on after reset");
    a_quiet_when_off: assert property (!wdt_enabled |=> !wdt_reset_req) else $error("overflow while off");
    a_pin_width: assert property ($rose(rst_pin_out) |-> rst_pin_out [*8] ##1 !rst_pin_out) else $error("pin width");
    a_req_with_pin: assert property ($rose(wdt_reset_req) |-> $rose(rst_pin_out)) else $error("pin not raised");
    a_key_reads_zero: assert property (sfr_req.rd && sfr_req.addr == 8'hA6 |=> sfr_rdata == 8'h00) else $error("key read");
    a_frozen_no_reset: assert property (power_down [*2] |=> !wdt_reset_req) else $error("overflow frozen");
    a_hit_decode: assert property (sfr_hit == ((sfr_req.wr || sfr_req.rd) && sfr_req.addr[7:1] == 7'h53))
        else $error("hit decode");
endmodule // wdt_top_assertions
bind wdt_top wdt_top_assertions wdt_top_assertions_i (.clk(clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .power_down(power_down), .idle_mode(idle_mode), .wake_int_n(wake_int_n),
    .wdt_enabled(wdt_enabled), .wdt_reset_req(wdt_reset_req), .rst_pin_out(rst_pin_out));

/* File: tb_wdt_top.sv */
`timescale 1ns/1ns
module tb_wdt_top;
    logic                     clk = 0, nrst = 0, pd = 0, idl = 0, wk = 1;
    logic                     hit, en, rq, pin, hs;
    wdt_pkg::wdt_sfr_req_type req = '0;
    logic [7:0]               rdat, v;
    logic [31:0]              rnd = 32'h5077;
    int                       err_count = 0, check_count = 0, m_sel = 0;
    always #20 clk = ~clk;
    wdt_top wdt_top_i (.clk(clk), .nrst(nrst), .sfr_req(req), .sfr_rdata(rdat), .sfr_hit(hit), .power_down(pd),
        .idle_mode(idl), .wake_int_n(wk), .wdt_enabled(en), .wdt_reset_req(rq), .rst_pin_out(pin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s exp %0h seen %0h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req = '{w, !w, a, d};
        @(negedge clk);
        v = rdat;
        hs = hit;
    endtask
    task automatic wt(input int n);
        req = '0;
        repeat (n) @(negedge clk);
    endtask
    task automatic key();
        acc(1'b1, 8'hA6, 8'h1E);
        acc(1'b1, 8'hA6, 8'hE1);
    endtask
    // Overflow one edge after the model's limit, then the pin stands eight cycles
    task automatic span(input int x);
        wt((2 ** (14 + m_sel)) - 1 + x);
        chk("reset_req", rq, 8'h00);
        wt(1);
        chk("reset_req", rq, 8'h01);
        chk("reset_pin", pin, 8'h01);
        wt(1);
        chk("reset_req", rq, 8'h00);
        wt(6);
        chk("reset_pin", pin, 8'h01);
        wt(1);
        chk("reset_pin", pin, 8'h00);
        chk("enabled", en, 8'h01);
        $display("overflow test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #4000000;
        err_count++;
        results();
    end
    initial
    begin
        repeat (8) @(negedge clk);
        nrst = 1;
        acc(1'b0, 8'hA6, 8'h00);
        chk("key_read", v, 8'h00);
        chk("key_hit", hs, 8'h01);
        acc(1'b0, 8'hA7, 8'h00);
        chk("sel_reset", v, 8'h00);
        rnd = lfsr(rnd);
        acc(1'b0, {4'h5, rnd[3:0]}, 8'h00);
        chk("unmapped", v, 8'h00);
        chk("unmapped_hit", hs, 8'h00);
        $display("register test done");
        acc(1'b1, 8'hA6, 8'hE1);
        chk("enabled", en, 8'h00);
        rnd = lfsr(rnd);
        acc(1'b1, 8'hA6, 8'h1E);
        acc(1'b1, 8'hA6, rnd[7:0] ^ {7'h00, rnd[7:0] == 8'hE1});
        chk("enabled", en, 8'h00);
        key();
        chk("enabled", en, 8'h01);
        $display("key test done");
        wt(5000);
        key();
        span(0);
        key();
        pd = 1;
        wt(100);
        pd = 0;
        wk = 0;
        wt(50);
        wk = 1;
        span(1);
        pd = 1;
        wt(5);
        pd = 0;
        wk = 0;
        wt(5);
        wk = 1;
        idl = 1;
        key();
        acc(1'b1, 8'hA7, 8'h01);
        m_sel = 1;
        acc(1'b0, 8'hA7, 8'h00);
        chk("sel", v, 8'h01);
        span(-2);
        nrst = 0;
        wt(2);
        nrst = 1;
        chk("enabled", en, 8'h00);
        acc(1'b0, 8'hA7, 8'h00);
        chk("sel_reset", v, 8'h00);
        key();
        chk("enabled", en, 8'h01);
        $display("reset test done");
        results();
    end
endmodule // tb_wdt_top
